//--- uwrx_top.sv
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module uwrx_top
  import uwrx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        rx_pin,
  input  wire logic        tx_pin_in,
  output logic             tx_pin_out,
  output logic             tx_pin_oe,
  input  wire logic        tx_serial,
  output logic             tx_enable_bit,
  output logic             tx_polarity_bit,
  output logic             rx_req
);
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic split3(input logic [2:0] s);
    split3 = (s != 3'b000) && (s != 3'b111);
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0]     ctrl1_reg;
  logic [12:0]    baud_reg;
  logic           rx_enable_reg;
  logic           tx_enable_reg;
  logic           standby_reg;
  logic           tx_dir_reg;
  logic           full_reg;
  logic           idle_reg;
  logic           ovr_reg;
  logic           noise_flag_reg;
  logic           fe_reg;
  logic [8:0]     data_reg;
  logic [31:0]    rdata_reg;
  logic           rx_sync1_reg;
  logic           rx_sync2_reg;
  logic           txp_sync1_reg;
  logic           txp_sync2_reg;
  logic [12:0]    div_cnt_reg;
  uwrx_state_type state_reg;
  logic [4:0]     rt_reg;
  logic [3:0]     bit_cnt_reg;
  logic [8:0]     shift_reg;
  logic [2:0]     hist_reg;
  logic [1:0]     vote_reg;
  logic [2:0]     ver_reg;
  logic           frame_noise_reg;
  logic           prev_bit_reg;
  logic [7:0]     idle_cnt_reg;
  logic           idle_armed_reg;

  logic           loop_mode;
  logic           single_wire;
  logic           char9;
  logic           rx_in;
  logic           tick;
  logic [4:0]     rt_now;
  logic           edge_start;
  logic           edge_inframe;
  logic           bit_done;
  logic           bit_val;
  logic [3:0]     last_bit;
  logic           addr_mark;
  logic           frame_done;
  logic [2:0]     stop_smp;
  logic           stop_bad;
  logic           stop_noise;
  logic [7:0]     idle_thr;
  logic           idle_reach;
  logic           idle_wake;
  logic           wr_ctrl2;
  logic           wr_stat1;
  logic           take_frame;

  assign loop_mode       = ctrl1_reg[BIT_LOOP];
  assign single_wire     = loop_mode & ctrl1_reg[BIT_RX_SOURCE_SEL];
  assign char9           = ctrl1_reg[BIT_CHAR9];
  assign wr_ctrl2        = wr && (addr == OFS_CTRL_TWO);
  assign wr_stat1        = wr && (addr == OFS_STAT_ONE);
  assign rdata           = rdata_reg;
  assign tx_enable_bit   = tx_enable_reg;
  assign tx_polarity_bit = ctrl1_reg[BIT_TX_POLARITY_BIT];

  // ----------------------------------------------------------------------
  // pin synchronisers and input routing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_sync1_reg  <= 1'b1;
      rx_sync2_reg  <= 1'b1;
      txp_sync1_reg <= 1'b1;
      txp_sync2_reg <= 1'b1;
    end else begin
      rx_sync1_reg  <= rx_pin;
      rx_sync2_reg  <= rx_sync1_reg;
      txp_sync1_reg <= tx_pin_in;
      txp_sync2_reg <= txp_sync1_reg;
    end
  end

  // polarity must match the transmitter's for the loop to be heard
  always_comb begin
    if (!loop_mode) begin
      rx_in = rx_sync2_reg ^ ctrl1_reg[BIT_RX_POLARITY_BIT];
    end else if (ctrl1_reg[BIT_RX_SOURCE_SEL]) begin
      rx_in = txp_sync2_reg ^ ctrl1_reg[BIT_RX_POLARITY_BIT]; // see R16 see R17 see R20
    end else begin
      rx_in = tx_serial ^ ctrl1_reg[BIT_RX_POLARITY_BIT]; // see R21 see R22
    end
  end

  // tx pin turns round only in single-wire operation
  assign tx_pin_out = tx_serial;
  assign tx_pin_oe  = single_wire ? tx_dir_reg : tx_enable_reg; // see R19

  // ----------------------------------------------------------------------
  // oversample tick
  // ----------------------------------------------------------------------
  assign tick = ({1'b0, div_cnt_reg} + 14'h0001) >= {1'b0, baud_reg};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_reg <= 13'h0000;
    end else if (tick) begin
      div_cnt_reg <= 13'h0000; // see R23
    end else begin
      div_cnt_reg <= div_cnt_reg + 13'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // receive sequencer
  // ----------------------------------------------------------------------
  assign rt_now       = (rt_reg == RT_PER_BIT) ? 5'h01 : rt_reg + 5'h01;
  assign edge_start   = tick && (hist_reg == 3'b111) && !rx_in;
  assign edge_inframe = tick && prev_bit_reg && hist_reg[0] && !rx_in
                        && (rt_now > 5'h01) && (rt_now <= RT_VER_C);
  assign last_bit     = char9 ? 4'h8 : 4'h7;
  assign bit_done     = tick && (state_reg == ST_DATA) && (rt_now == RT_SMP_C);
  assign bit_val      = maj3({vote_reg, rx_in});
  assign addr_mark    = bit_done && (bit_cnt_reg == last_bit) && bit_val;
  assign stop_smp     = {vote_reg, rx_in};
  assign frame_done   = tick && (state_reg == ST_STOP) && (rt_now == RT_SMP_C);
  assign stop_bad     = !maj3(stop_smp); // see R1 see R2 see R5
  assign stop_noise   = split3(stop_smp); // see R4

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hist_reg <= 3'b000;
    end else if (tick) begin
      hist_reg <= {hist_reg[1:0], rx_in};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg       <= ST_HUNT;
      rt_reg          <= 5'h00;
      bit_cnt_reg     <= 4'h0;
      shift_reg       <= 9'h000;
      vote_reg        <= 2'b00;
      ver_reg         <= 3'b000;
      frame_noise_reg <= 1'b0;
      prev_bit_reg    <= 1'b0;
    end else if (!rx_enable_reg) begin
      state_reg <= ST_HUNT;
    end else if (tick) begin
      rt_reg <= rt_now;
      if (rt_now == RT_SMP_A) begin
        vote_reg[1] <= rx_in;
      end
      if (rt_now == RT_SMP_B) begin
        vote_reg[0] <= rx_in;
      end
      case (state_reg)
        ST_HUNT: begin
          if (edge_start) begin
            state_reg       <= ST_START;
            rt_reg          <= 5'h01;
            frame_noise_reg <= 1'b0;
          end
        end
        ST_START: begin
          if (rt_now == RT_VER_A) begin
            ver_reg[2] <= rx_in;
          end
          if (rt_now == RT_VER_B) begin
            ver_reg[1] <= rx_in;
          end
          if (rt_now == RT_VER_C) begin
            if (maj3({ver_reg[2:1], rx_in})) begin
              state_reg <= ST_HUNT;
            end else begin
              frame_noise_reg <= |{ver_reg[2:1], rx_in};
            end
          end
          if (rt_now == RT_PER_BIT) begin
            state_reg    <= ST_DATA;
            bit_cnt_reg  <= 4'h0;
            prev_bit_reg <= 1'b0;
          end
        end
        ST_DATA: begin
          if (edge_inframe) begin
            rt_reg <= 5'h01; // see R6
          end
          if (bit_done) begin
            shift_reg       <= {bit_val, shift_reg[8:1]}; // see R23
            prev_bit_reg    <= bit_val;
            frame_noise_reg <= frame_noise_reg | split3({vote_reg, rx_in});
          end
          if (rt_now == RT_PER_BIT) begin
            if (bit_cnt_reg == last_bit) begin
              state_reg <= ST_STOP; // see R24
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_STOP: begin
          if (edge_inframe) begin
            rt_reg <= 5'h01; // see R6
          end
          if (frame_done) begin
            state_reg <= ST_HUNT;
          end
        end
        default: begin
          state_reg <= ST_HUNT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // idle detection
  // ----------------------------------------------------------------------
  assign idle_thr   = (char9 ? IDLE_BITS_9 : IDLE_BITS_8) * {3'b000, RT_PER_BIT};
  assign idle_reach = tick && rx_in && (idle_cnt_reg == idle_thr - 8'h01);
  assign idle_wake  = standby_reg && !ctrl1_reg[BIT_WAKE]
                      && (idle_cnt_reg >= idle_thr); // see R9 see R15

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt_reg <= 8'h00;
    end else if (ctrl1_reg[BIT_ILT] && (state_reg != ST_HUNT)) begin
      idle_cnt_reg <= 8'h00; // see R11
    end else if (tick) begin
      if (!rx_in) begin
        idle_cnt_reg <= 8'h00;
      end else if (idle_cnt_reg < idle_thr) begin
        idle_cnt_reg <= idle_cnt_reg + 8'h01; // see R25
      end
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_reg  <= CTRL_RST;
      baud_reg   <= BAUD_RST;
      tx_dir_reg <= 1'b0;
    end else if (wr) begin
      if (addr == OFS_CTRL_ONE) begin
        ctrl1_reg <= wdata[7:0];
      end
      if (addr == OFS_BAUD) begin
        baud_reg <= wdata[12:0];
      end
      if (addr == OFS_STAT_TWO) begin
        tx_dir_reg <= wdata[BIT_TX_PIN_DIRECTION]; // see R19
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_enable_reg <= 1'b0;
      tx_enable_reg <= 1'b0;
    end else if (wr_ctrl2) begin
      rx_enable_reg <= wdata[BIT_RXEN];
      tx_enable_reg <= wdata[BIT_TXEN];
    end
  end

  // a software write wins over a wakeup in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      standby_reg <= 1'b0;
    end else if (wr_ctrl2) begin
      standby_reg <= wdata[BIT_STANDBY]; // see R26
    end else if (idle_wake || (addr_mark && ctrl1_reg[BIT_WAKE])) begin
      standby_reg <= 1'b0; // see R12 see R13
    end
  end

  // ----------------------------------------------------------------------
  // status flags, write one to clear, set beats clear
  // ----------------------------------------------------------------------
  assign take_frame = frame_done && !standby_reg && !full_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      full_reg       <= 1'b0;
      fe_reg         <= 1'b0;
      noise_flag_reg <= 1'b0;
      ovr_reg        <= 1'b0;
    end else begin
      full_reg <= (full_reg && !(wr_stat1 && wdata[BIT_FULL]))
                  || take_frame; // see R8 see R13
      fe_reg <= (fe_reg && !(wr_stat1 && wdata[BIT_FRAME]))
                || (take_frame && stop_bad); // see R3
      noise_flag_reg <= (noise_flag_reg && !(wr_stat1 && wdata[BIT_NOISE]))
                        || (take_frame && (stop_noise || frame_noise_reg));
      ovr_reg <= (ovr_reg && !(wr_stat1 && wdata[BIT_OVR]))
                 || (frame_done && !standby_reg && full_reg);
    end
  end

  // idle flag needs a new frame before it can fire again
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_reg       <= 1'b0;
      idle_armed_reg <= 1'b0;
    end else begin
      idle_reg <= (idle_reg && !(wr_stat1 && wdata[BIT_IDLE]))
                  || (idle_reach && idle_armed_reg && !standby_reg); // see R10
      idle_armed_reg <= take_frame
                        || (idle_armed_reg
                            && !(idle_reach && !standby_reg));
    end
  end

  // standby still captures the character for software to inspect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_reg <= 9'h000;
    end else if (frame_done && !(full_reg && !standby_reg)) begin
      data_reg <= char9 ? shift_reg : {1'b0, shift_reg[8:1]}; // see R8 see R24
    end
  end

  assign rx_req = !standby_reg && (full_reg || idle_reg); // see R7

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        OFS_CTRL_ONE: rdata_reg <= {24'h000000, ctrl1_reg};
        OFS_CTRL_TWO: rdata_reg <= {28'h0000000, tx_enable_reg,
                                    rx_enable_reg, standby_reg, 1'b0};
        OFS_STAT_ONE: rdata_reg <= {26'h0000000, full_reg, idle_reg,
                                    ovr_reg, noise_flag_reg, fe_reg, 1'b0};
        OFS_STAT_TWO: rdata_reg <= {30'h00000000, tx_dir_reg, 1'b0};
        OFS_DATA:     rdata_reg <= {23'h000000, data_reg};
        OFS_BAUD:     rdata_reg <= {19'h00000, baud_reg};
        default:      rdata_reg <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_fe_with_full: assert property ( // see R3
    take_frame && stop_bad |=> full_reg && fe_reg && $rose(full_reg))
    else $error("framing error not raised with rx full");

  a_stop_noise: assert property ( // see R4
    take_frame && stop_noise |=> noise_flag_reg)
    else $error("stop sample disagreement missed");

  a_fe_majority: assert property ( // see R5
    take_frame && !stop_bad && !fe_reg && !wr_stat1 |=> !fe_reg)
    else $error("framing error on good stop bit");

  a_req_suppress: assert property ( // see R7
    standby_reg |-> !rx_req ##1 (!$rose(full_reg) && !$rose(idle_reg)))
    else $error("request or flag raised in standby");

  a_standby_no_full: assert property ( // see R8
    frame_done && standby_reg && !full_reg |=> !full_reg)
    else $error("rx full set in standby");

  a_idle_wake: assert property ( // see R9
    idle_wake && !wr_ctrl2 |=> !standby_reg ##1 !$rose(idle_reg))
    else $error("idle wakeup misbehaved");

  a_addr_wake: assert property ( // see R12
    addr_mark && standby_reg && ctrl1_reg[BIT_WAKE] && !wr_ctrl2
    && !full_reg |=> !standby_reg ##[1:200] full_reg)
    else $error("address frame did not wake and fill");

  a_loop_feed: assert property ( // see R21
    loop_mode && !ctrl1_reg[BIT_RX_SOURCE_SEL] |-> rx_in == (tx_serial
                                         ^ ctrl1_reg[BIT_RX_POLARITY_BIT]))
    else $error("loop input not from transmitter");

  a_tx_dir: assert property ( // see R19
    single_wire |-> tx_pin_oe == tx_dir_reg)
    else $error("tx pin direction wrong in single-wire");

  a_resync: assert property ( // see R6
    rx_enable_reg && edge_inframe && (state_reg == ST_DATA) |=> rt_reg == 5'h01)
    else $error("oversample counter not realigned");
endmodule
`default_nettype wire

//--- uwrx_pkg.sv
//
// Contract
// R1 - missing logic 1 at the stop bit sets the framing error flag
// R2 - a received break character also sets the framing error flag
// R3 - framing error flag sets in the same cycle as the rx full flag
// R4 - stop samples at ticks 8, 9, 10 disagreeing flag a noise error
// R5 - majority zero among the three stop samples is a framing error
// R6 - realign the oversample counter on each valid falling edge in a frame
// R7 - setting the standby bit suppresses all receiver requests
// R8 - in standby data still loads but the rx full flag stays clear
// R9 - wake select zero: idle input clears standby
// R10 - the waking idle character sets neither idle nor rx full flag
// R11 - idle-type bit: idle counting starts after start bit or after stop bit
// R12 - wake select one: frame with msb one clears standby
// R13 - address frame clears standby before stop bit, then sets rx full
// R14 - sender separates messages by idle characters, none inside a message
// R15 - standby set on an idle line may wake at once
// R16 - loop mode disconnects the receive pin from the receiver
// R17 - loop with source one: receiver listens to the transmit pin
// R18 - software enables transmitter and receiver before single-wire or loop
// R19 - single-wire: tx direction bit makes tx pin input or output
// R20 - single-wire: data from the transmit pin inverted by rx polarity
// R21 - loop with source zero: receiver fed from transmitter output
// R22 - loop works only when rx and tx polarity bits match
// R23 - oversample tick runs at sixteen times baud and samples each bit
// R24 - length bit selects 8 or 9 data bits, ninth kept high; the code reads the ninth bit as zero in 8-bit mode
// R25 - idle flag after 10 or 11 consecutive ones
// R26 - standby set by software, cleared by hardware only on wakeup
//
package uwrx_pkg;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
  localparam logic [7:0] OFS_STAT_ONE   = 8'h08;
  localparam logic [7:0] OFS_STAT_TWO   = 8'h0C;
  localparam logic [7:0] OFS_DATA       = 8'h10;
  localparam logic [7:0] OFS_BAUD       = 8'h14;
  // control_reg_one fields
  localparam int BIT_LOOP    = 7;
  localparam int BIT_RX_SOURCE_SEL    = 5;
  localparam int BIT_CHAR9   = 4;
  localparam int BIT_WAKE    = 3;
  localparam int BIT_ILT     = 2;
  localparam int BIT_RX_POLARITY_BIT   = 1;
  localparam int BIT_TX_POLARITY_BIT   = 0;
  // control_reg_two fields
  localparam int BIT_TXEN    = 3;
  localparam int BIT_RXEN    = 2;
  localparam int BIT_STANDBY = 1;
  // status_reg_one fields
  localparam int BIT_FULL    = 5;
  localparam int BIT_IDLE    = 4;
  localparam int BIT_OVR     = 3;
  localparam int BIT_NOISE   = 2;
  localparam int BIT_FRAME   = 1;
  // status_reg_two fields
  localparam int BIT_TX_PIN_DIRECTION   = 1;
  // reset values
  localparam logic [12:0] BAUD_RST  = 13'h0010;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam logic [4:0] RT_PER_BIT = 5'h10;
  localparam logic [4:0] RT_VER_A   = 5'h03;
  localparam logic [4:0] RT_VER_B   = 5'h05;
  localparam logic [4:0] RT_VER_C   = 5'h07;
  localparam logic [4:0] RT_SMP_A   = 5'h08;
  localparam logic [4:0] RT_SMP_B   = 5'h09;
  localparam logic [4:0] RT_SMP_C   = 5'h0A;
  localparam logic [7:0] IDLE_BITS_8 = 8'h0A;
  localparam logic [7:0] IDLE_BITS_9 = 8'h0B;

  typedef enum logic [1:0] {
    ST_HUNT  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b10,
    ST_STOP  = 2'b11
  } uwrx_state_type;
endpackage

//--- uwrx_line_src.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// remote transmitter on the serial line, one tick per clock
// ----------------------------------------------------------------
module uwrx_line_src (
  input  wire logic clk,
  input  wire logic inv,
  output logic      line
);
  logic line_q = 1'b1;
  // bench may stretch bits to model a slow sender
  int   bit_len = 16;

  // inv models an inverting driver; released line sits high, or low when inv is set
  assign line = line_q ^ inv;

  // ----------------------------------------------------------------
  // one frame, bit_len clocks a bit, lsb first
  // ----------------------------------------------------------------
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    logic b;
    // one bit of gap only, never an idle character inside a message
    repeat (16) @(posedge clk) line_q <= 1'b1;
    for (int i = 0; i < nb + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i > nb) ? stop : d[i-1];
      repeat (bit_len) @(posedge clk) line_q <= b;
    end
    @(posedge clk) line_q <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- uart_rx_wakeup_loop_test.sv
`timescale 1ns/10ps
`default_nettype none
module uart_rx_wakeup_loop_test;
  import uwrx_pkg::*;
  logic        clk   = 1'b0;
  logic        nrst  = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        inv_rx = 1'b0;
  logic        inv_tx = 1'b0;
  logic        inv_pin = 1'b0;
  wire logic [31:0] rdata;
  wire logic   rx_pin, tx_pin_in, tx_pin_out, tx_pin_oe, tx_serial;
  wire logic   pin_line, tx_enable_bit, tx_polarity_bit, rx_req;
  int          mismatches = 0;
  int          checks = 0;

  always #4 clk = ~clk;
  // shared transmit pin: our drive wins while enabled
  assign tx_pin_in = tx_pin_oe ? tx_pin_out : pin_line;

  uwrx_line_src src_rx (.clk(clk), .inv(inv_rx), .line(rx_pin));
  uwrx_line_src src_tx (.clk(clk), .inv(inv_tx), .line(tx_serial));
  uwrx_line_src src_pin (.clk(clk), .inv(inv_pin), .line(pin_line));

  uwrx_top dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_pin(rx_pin),
    .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
    .tx_serial(tx_serial), .tx_enable_bit(tx_enable_bit),
    .tx_polarity_bit(tx_polarity_bit), .rx_req(rx_req));

  // ----------------------------------------------------------------
  // bus tasks and compare
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    chk(d & m, e);
  endtask

  // bounded poll of status one until all bits of m are set
  task automatic wait_stat(input logic [31:0] m);
    logic [31:0] d;
    int n;
    n = 0;
    d = 32'h0;
    while ((d & m) !== m && n < 300) begin
      rd_reg(OFS_STAT_ONE, d);
      n++;
    end
    if ((d & m) !== m) begin
      mismatches++;
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(OFS_BAUD, 32'h1FFF, {19'h0, BAUD_RST});
    rd_chk(OFS_CTRL_TWO, 32'hFF, 32'h0);
    wr_reg(OFS_BAUD, 32'h1);
    wr_reg(OFS_CTRL_TWO, 32'h0C);
    for (int m = 0; m < 2; m++) begin
      wr_reg(OFS_CTRL_ONE, m ? 32'h10 : 32'h0);
      wr_reg(OFS_STAT_ONE, 32'h3E);
      src_rx.send(9'h1A5, 8 + m, 1'b1);
      wait_stat(32'h20);
      rd_chk(OFS_DATA, 32'h1FF, m ? 32'h1A5 : 32'hA5);
      rd_chk(OFS_STAT_ONE, 32'h16, 32'h0);
      chk({31'h0, rx_req}, 32'h1);
      repeat (100) @(posedge clk);
      rd_chk(OFS_STAT_ONE, 32'h10, 32'h0);
      wait_stat(32'h10);
    end
    // slow sender, one clock longer a bit; falling edges realign
    src_rx.bit_len = 17;
    wr_reg(OFS_STAT_ONE, 32'h3E);
    src_rx.send(9'h0A5, 9, 1'b1);
    src_rx.bit_len = 16;
    wait_stat(32'h20);
    rd_chk(OFS_DATA, 32'h1FF, 32'hA5);
    rd_chk(OFS_STAT_ONE, 32'h06, 32'h0);
    // idle count after stop: all-ones data must not hasten idle
    wr_reg(OFS_CTRL_ONE, 32'h04);
    wr_reg(OFS_STAT_ONE, 32'h3E);
    src_rx.send(9'h0FF, 8, 1'b1);
    wait_stat(32'h20);
    repeat (40) @(posedge clk);
    rd_chk(OFS_STAT_ONE, 32'h10, 32'h0);
    wait_stat(32'h10);
    // bad stop bit, then a break
    for (int k = 0; k < 2; k++) begin
      wr_reg(OFS_STAT_ONE, 32'h3E);
      src_rx.send(k ? 9'h000 : 9'h03C, 8, 1'b0);
      wait_stat(32'h20);
      rd_chk(OFS_STAT_ONE, 32'h22, 32'h22);
      rd_chk(OFS_DATA, 32'h1FF, k ? 32'h0 : 32'h3C);
    end
    // address mark wakeup; full still set on entry
    wr_reg(OFS_CTRL_ONE, 32'h08);
    wr_reg(OFS_CTRL_TWO, 32'h0E);
    repeat (2) @(posedge clk);
    chk({31'h0, rx_req}, 32'h0);
    wr_reg(OFS_STAT_ONE, 32'h3E);
    src_rx.send(9'h012, 8, 1'b1);
    repeat (4) @(posedge clk);
    rd_chk(OFS_DATA, 32'h1FF, 32'h12);
    rd_chk(OFS_STAT_ONE, 32'h3E, 32'h0);
    rd_chk(OFS_CTRL_TWO, 32'h02, 32'h02);
    src_rx.send(9'h085, 8, 1'b1);
    wait_stat(32'h20);
    rd_chk(OFS_DATA, 32'h1FF, 32'h85);
    rd_chk(OFS_CTRL_TWO, 32'h02, 32'h0);
    // idle line wakeup on a line that is already idle
    repeat (200) @(posedge clk);
    wr_reg(OFS_CTRL_ONE, 32'h0);
    wr_reg(OFS_STAT_ONE, 32'h3E);
    wr_reg(OFS_CTRL_TWO, 32'h0E);
    repeat (4) @(posedge clk);
    rd_chk(OFS_CTRL_TWO, 32'h02, 32'h0);
    rd_chk(OFS_STAT_ONE, 32'h30, 32'h0);
    // internal loop; the pin carries a clashing bad frame
    wr_reg(OFS_CTRL_ONE, 32'h80);
    wr_reg(OFS_STAT_ONE, 32'h3E);
    fork
      src_tx.send(9'h05A, 8, 1'b1);
      src_rx.send(9'h0C3, 8, 1'b0);
    join
    wait_stat(32'h20);
    rd_chk(OFS_DATA, 32'h1FF, 32'h5A);
    rd_chk(OFS_STAT_ONE, 32'h02, 32'h0);
    chk({31'h0, tx_pin_oe}, 32'h1);
    // both polarities set together keep the loop readable
    wr_reg(OFS_CTRL_ONE, 32'h83);
    inv_tx <= 1'b1;
    wr_reg(OFS_STAT_ONE, 32'h3E);
    chk({31'h0, tx_polarity_bit}, 32'h1);
    src_tx.send(9'h066, 8, 1'b1);
    wait_stat(32'h20);
    rd_chk(OFS_DATA, 32'h1FF, 32'h66);
    // single wire, pin as input, inverted receive
    wr_reg(OFS_CTRL_ONE, 32'hA2);
    inv_pin <= 1'b1;
    wr_reg(OFS_STAT_ONE, 32'h3E);
    chk({31'h0, tx_pin_oe}, 32'h0);
    src_pin.send(9'h03C, 8, 1'b1);
    wait_stat(32'h20);
    rd_chk(OFS_DATA, 32'h1FF, 32'h3C);
    wr_reg(OFS_STAT_TWO, 32'h02);
    #1;
    chk({31'h0, tx_pin_oe}, 32'h1);
    chk({31'h0, tx_pin_out}, {31'h0, tx_serial});
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
